/* File: hw/cpw_pkg.sv */
// Behaviour
// - mode field 0000 switches the unit off and holds its prescaler, duty latch and output latch reset
// - codes 0100..0111 capture on falling, rising, 4th rising, 16th rising edge
// - code 1000 drives output high, 1001 low, on match; both set the flag
// - code 1010 only sets the flag on match; output unchanged
// - code 1011 sets the flag and pulses the special-event trigger on match
// - mode codes 11xx select pwm with up to ten duty bits
// - control bits 5..4 are the two low duty bits, used only in pwm
// - control bits 7..6 read back as zero
// - a capture copies the whole 16-bit timer-one count into the value bytes
// - each capture sets event flag bit 2; it stays until software clears it
// - a new capture overwrites the value even when not yet read
// - a port write changing an output pin level can trigger a capture
// - the prescaler clears when off, outside capture, and on reset
// - direct prescale switches keep the count; software goes through off first
// - compare checks value against timer one each cycle; action and flag together
// - the special-event trigger resets timer one, making value a period
// - writing zero to the control register forces the output latch low
// - pwm period roll clears timer two, sets pin unless duty zero, reloads high byte
// - pwm pin clears when buffered duty equals timer two with two phase bits
// - in pwm the high value byte is read-only and holds the buffered duty
// - a duty longer than the period never clears the pin
`default_nettype none
package cpw_pkg;
   // bus geometry
   localparam int ADDR_W = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_VAL_LO = 8'h15;
   localparam logic [7:0] IDX_VAL_HI = 8'h16;
   localparam logic [7:0] IDX_CTRL = 8'h17;
   localparam logic [7:0] IDX_ENABLES = 8'h8C;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = ADDR_W'({IDX_FLAGS, 2'h0});
   localparam logic [ADDR_W-1:0] ADDR_VAL_LO = ADDR_W'({IDX_VAL_LO, 2'h0});
   localparam logic [ADDR_W-1:0] ADDR_VAL_HI = ADDR_W'({IDX_VAL_HI, 2'h0});
   localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'({IDX_CTRL, 2'h0});
   localparam logic [ADDR_W-1:0] ADDR_ENABLES = ADDR_W'({IDX_ENABLES, 2'h0});
   // field positions and reset values
   localparam int EVENT_BIT = 2;
   localparam int DUTY_LSB_UPPER = 5;
   localparam int DUTY_LSB_LOWER = 4;
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] LSB_ZERO = 2'h0;
   // mode field codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
   localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
   localparam logic [1:0] MODE_PWM_TOP = 2'h3;
   localparam logic [1:0] MODE_CAP_TOP = 2'h1;
   localparam logic [1:0] MODE_CMP_TOP = 2'h2;
   // prescaler: zero, step, and last count before the divided capture fires
   localparam logic [3:0] PRESCALE_ZERO = 4'h0;
   localparam logic [3:0] PRESCALE_LAST4 = 4'h3;
   localparam logic [3:0] PRESCALE_LAST16 = 4'hF;
   localparam logic [3:0] PRESCALE_STEP = 4'h1;

   typedef enum logic [1:0] {CPW_OFF, CPW_CAPTURE, CPW_COMPARE, CPW_PWM} cpw_op_t;

   // coarse operation class from the mode field
   function automatic cpw_op_t cpw_op_of(input logic [3:0] mode);
      cpw_op_t op;
      op = CPW_OFF;
      case (mode[3:2])
         MODE_CAP_TOP: op = CPW_CAPTURE;
         MODE_CMP_TOP: op = CPW_COMPARE;
         MODE_PWM_TOP: op = CPW_PWM;
         default: op = CPW_OFF;
      endcase
      return op;
   endfunction
endpackage
`default_nettype wire

/* File: hw/cpw_cap_if.sv */
`default_nettype none
// link between the unit and its edge/prescale detector
interface cpw_cap_if;
   logic [3:0] mode;
   logic pin_level;
   logic capture;
   modport unit (output mode, output pin_level, input capture);
   modport detect (input mode, input pin_level, output capture);
endinterface
`default_nettype wire

/* File: hw/cpw_edge_prescale.sv */
`default_nettype none
module cpw_edge_prescale import cpw_pkg::*; (
   // clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // mode in, capture pulse out
   cpw_cap_if.detect cap
);
   logic pin_prev_r;
   logic [3:0] count_r;
   logic capture_r;
   logic rise;
   logic fall;
   logic in_capture;
   logic divided;
   logic [3:0] last;

   // one edge pulse per transition, found against the previous sample
   assign rise = cap.pin_level && !pin_prev_r;
   assign fall = !cap.pin_level && pin_prev_r;
   assign in_capture = cpw_op_of(cap.mode) == CPW_CAPTURE;
   assign divided = (cap.mode == MODE_CAP_RISE4) || (cap.mode == MODE_CAP_RISE16);
   assign last = (cap.mode == MODE_CAP_RISE4) ? PRESCALE_LAST4 : PRESCALE_LAST16;
   assign cap.capture = capture_r;

   // pin history keeps tracking while off, so switching on sees only real edges
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_prev_r <= 1'b0;
      end else begin
         pin_prev_r <= cap.pin_level;
      end
   end

   // prescaler; a direct code switch keeps the count, >= guards a 16-to-4 switch
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         count_r <= PRESCALE_ZERO;
      end else if (!in_capture) begin
         count_r <= PRESCALE_ZERO;
      end else if (divided && rise) begin
         count_r <= (count_r >= last) ? PRESCALE_ZERO : count_r + PRESCALE_STEP;
      end
   end

   // capture strobe per selected event
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         capture_r <= 1'b0;
      end else begin
         capture_r <= in_capture && (((cap.mode == MODE_CAP_FALL) && fall) ||
                      ((cap.mode == MODE_CAP_RISE) && rise) ||
                      (divided && rise && (count_r >= last)));
      end
   end

   prescale_clear_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !in_capture |=> count_r == PRESCALE_ZERO)
      else $error("prescaler not cleared outside capture");
   every_fourth_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cap.mode == MODE_CAP_RISE4) && rise && (count_r == PRESCALE_LAST4) |=> capture_r && count_r == PRESCALE_ZERO)
      else $error("fourth rising edge did not capture");
endmodule // cpw_edge_prescale
`default_nettype wire

/* File: hw/cpw_unit.sv */
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
module cpw_unit import cpw_pkg::*; (
   // clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // timer one
   input wire logic [15:0] timer_one_count_in,
   output logic timer_one_reset_out,
   // timer two
   input wire logic [7:0] timer_two_count_in,
   input wire logic [7:0] timer_two_period_in,
   input wire logic timer_two_incr_in,
   input wire logic [1:0] timer_two_phase_in,
   output logic timer_two_clear_out,
   // shared pin
   input wire logic shared_unit_pin_in,
   output logic unit_pin_out
);
   // register file
   logic [CTRL_W-1:0] ctrl_r;
   logic [7:0] val_lo_r;
   logic [7:0] val_hi_r;
   logic flag_r;
   logic enable_r;
   logic [1:0] duty_latch_r;
   logic pin_latch_r;
   logic timer_one_reset_r;
   logic timer_two_clear_r;
   // bus state
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0] wdata_r;
   logic wstrb0_r;
   logic arready_r;
   logic rvalid_r;
   logic [7:0] rdata_r;
   logic [1:0] rresp_r;
   logic rd_ctrl_r;
   // decoded
   cpw_op_t op;
   logic [3:0] mode;
   logic wr_do;
   logic wr_hit;
   logic wr_flags;
   logic wr_val_lo;
   logic wr_val_hi;
   logic wr_ctrl;
   logic wr_enables;
   logic ctrl_zero_wr;
   logic cap_pulse;
   logic cmp_match;
   logic pwm_roll;
   logic pwm_off_match;
   logic [9:0] duty_next;
   logic [7:0] rd_byte;
   logic rd_hit;

   cpw_cap_if cap_link ();

   assign mode = ctrl_r[3:0];
   assign op = cpw_op_of(mode);
   assign cap_link.mode = mode;
   assign cap_link.pin_level = shared_unit_pin_in;
   assign cap_pulse = cap_link.capture;

   // edge detection and capture prescaler
   cpw_edge_prescale u_detect (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .cap(cap_link.detect)
   );

   // outputs straight from flops
   assign s_axi_awready_out = awready_r;
   assign s_axi_wready_out = wready_r;
   assign s_axi_bvalid_out = bvalid_r;
   assign s_axi_bresp_out = bresp_r;
   assign s_axi_arready_out = arready_r;
   assign s_axi_rvalid_out = rvalid_r;
   assign s_axi_rdata_out = {24'h000000, rdata_r};
   assign s_axi_rresp_out = rresp_r;
   assign timer_one_reset_out = timer_one_reset_r;
   assign timer_two_clear_out = timer_two_clear_r;
   assign unit_pin_out = pin_latch_r;

   // write decode; a write runs once both address and data are held
   assign wr_do = !awready_r && !wready_r && !bvalid_r;
   assign wr_flags = wr_do && wstrb0_r && (awaddr_r == ADDR_FLAGS);
   assign wr_val_lo = wr_do && wstrb0_r && (awaddr_r == ADDR_VAL_LO);
   assign wr_val_hi = wr_do && wstrb0_r && (awaddr_r == ADDR_VAL_HI);
   assign wr_ctrl = wr_do && wstrb0_r && (awaddr_r == ADDR_CTRL);
   assign wr_enables = wr_do && wstrb0_r && (awaddr_r == ADDR_ENABLES);
   assign wr_hit = (awaddr_r == ADDR_FLAGS) || (awaddr_r == ADDR_VAL_LO) || (awaddr_r == ADDR_VAL_HI) ||
                   (awaddr_r == ADDR_CTRL) || (awaddr_r == ADDR_ENABLES);
   assign ctrl_zero_wr = wr_ctrl && (wdata_r == BYTE_ZERO);

   // event sources
   assign cmp_match = (op == CPW_COMPARE) && ({val_hi_r, val_lo_r} == timer_one_count_in);
   assign pwm_roll = (op == CPW_PWM) && timer_two_incr_in && (timer_two_count_in == timer_two_period_in);
   assign duty_next = {val_lo_r, ctrl_r[DUTY_LSB_UPPER:DUTY_LSB_LOWER]};
   // a duty beyond the period never meets the count, so the pin stays set
   assign pwm_off_match = (op == CPW_PWM) &&
                          ({val_hi_r, duty_latch_r} == {timer_two_count_in, timer_two_phase_in});

   // write address channel; held until the response is taken
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         awready_r <= 1'b1;
         awaddr_r <= '0;
      end else if (awready_r && s_axi_awvalid_in) begin
         awready_r <= 1'b0;
         awaddr_r <= s_axi_awaddr_in;
      end else if (bvalid_r && s_axi_bready_in) begin
         awready_r <= 1'b1;
      end
   end

   // write data channel; only lane 0 carries register bits
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wready_r <= 1'b1;
         wdata_r <= BYTE_ZERO;
         wstrb0_r <= 1'b0;
      end else if (wready_r && s_axi_wvalid_in) begin
         wready_r <= 1'b0;
         wdata_r <= s_axi_wdata_in[7:0];
         wstrb0_r <= s_axi_wstrb_in[0];
      end else if (bvalid_r && s_axi_bready_in) begin
         wready_r <= 1'b1;
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready_in) begin
         bvalid_r <= 1'b0;
      end
   end

   // read mux; unused flag and enable bits read zero
   always_comb begin
      rd_byte = BYTE_ZERO;
      rd_hit = 1'b1;
      case (s_axi_araddr_in)
         ADDR_FLAGS: rd_byte[EVENT_BIT] = flag_r;
         ADDR_VAL_LO: rd_byte = val_lo_r;
         ADDR_VAL_HI: rd_byte = val_hi_r;
         ADDR_CTRL: rd_byte = {2'h0, ctrl_r};
         ADDR_ENABLES: rd_byte[EVENT_BIT] = enable_r;
         default: rd_hit = 1'b0;
      endcase
   end

   // read channel; data one cycle after the address is taken
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= BYTE_ZERO;
         rresp_r <= RESP_OKAY;
         rd_ctrl_r <= 1'b0;
      end else if (arready_r && s_axi_arvalid_in) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_byte;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         rd_ctrl_r <= s_axi_araddr_in == ADDR_CTRL;
      end else if (rvalid_r && s_axi_rready_in) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // control register; upper two bits are not stored
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= wdata_r[CTRL_W-1:0];
      end
   end

   // event enable; only stored, software gates its own interrupt with it
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         enable_r <= 1'b0;
      end else if (wr_enables) begin
         enable_r <= wdata_r[EVENT_BIT];
      end
   end

   // event flag; a hardware event wins over a clearing write in the same cycle
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         flag_r <= 1'b0;
      end else if (cap_pulse || cmp_match) begin
         flag_r <= 1'b1;
      end else if (wr_flags) begin
         flag_r <= wdata_r[EVENT_BIT];
      end
   end

   // low value byte; capture beats a software write
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         val_lo_r <= BYTE_ZERO;
      end else if (cap_pulse) begin
         val_lo_r <= timer_one_count_in[7:0];
      end else if (wr_val_lo) begin
         val_lo_r <= wdata_r;
      end
   end

   // high value byte; in pwm it is the buffered duty and ignores writes
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         val_hi_r <= BYTE_ZERO;
      end else if (cap_pulse) begin
         val_hi_r <= timer_one_count_in[15:8];
      end else if (pwm_roll) begin
         val_hi_r <= val_lo_r;
      end else if (wr_val_hi && (op != CPW_PWM)) begin
         val_hi_r <= wdata_r;
      end
   end

   // hidden two-bit duty latch, reloaded with the high byte
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         duty_latch_r <= LSB_ZERO;
      end else if (op == CPW_OFF) begin
         duty_latch_r <= LSB_ZERO;
      end else if (pwm_roll) begin
         duty_latch_r <= ctrl_r[DUTY_LSB_UPPER:DUTY_LSB_LOWER];
      end
   end

   // unit output latch, separate from the port data latch
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_latch_r <= 1'b0;
      end else if (ctrl_zero_wr || (op == CPW_OFF)) begin
         pin_latch_r <= 1'b0;
      end else if (cmp_match && (mode == MODE_CMP_SET)) begin
         pin_latch_r <= 1'b1;
      end else if (cmp_match && (mode == MODE_CMP_CLR)) begin
         pin_latch_r <= 1'b0;
      end else if (pwm_roll) begin
         pin_latch_r <= duty_next != 10'h000;
      end else if (pwm_off_match) begin
         pin_latch_r <= 1'b0;
      end
   end

   // one-cycle strobes to the timers
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         timer_one_reset_r <= 1'b0;
         timer_two_clear_r <= 1'b0;
      end else begin
         timer_one_reset_r <= cmp_match && (mode == MODE_CMP_TRIG);
         timer_two_clear_r <= pwm_roll;
      end
   end

   off_latch_low_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (mode == MODE_OFF) |=> !pin_latch_r)
      else $error("output latch not low while off");
   upper_ctrl_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (rvalid_r && rd_ctrl_r) |-> (s_axi_rdata_out[7:6] == 2'h0))
      else $error("control bits 7..6 read nonzero");
   capture_copies_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      cap_pulse |=> ({val_hi_r, val_lo_r} == $past(timer_one_count_in)) && flag_r)
      else $error("capture did not copy timer one and set flag");
   flag_sticky_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (flag_r && !wr_flags) |=> flag_r)
      else $error("event flag dropped without a clearing write");
   cmp_set_high_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cmp_match && (mode == MODE_CMP_SET) && !wr_ctrl) |=> pin_latch_r && flag_r)
      else $error("compare set did not drive output high");
   cmp_clear_low_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cmp_match && (mode == MODE_CMP_CLR)) |=> !pin_latch_r && flag_r)
      else $error("compare clear did not drive output low");
   cmp_soft_keep_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cmp_match && (mode == MODE_CMP_SOFT) && !wr_ctrl) |=> $stable(pin_latch_r) && flag_r)
      else $error("soft compare changed the output");
   special_trigger_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cmp_match && (mode == MODE_CMP_TRIG)) |=> timer_one_reset_r ##1 !timer_one_reset_r || cmp_match)
      else $error("special event trigger missing");
   pwm_reload_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (pwm_roll && !cap_pulse) |=> (val_hi_r == $past(val_lo_r)) && timer_two_clear_r)
      else $error("pwm period roll did not reload duty");
   zero_write_low_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      ctrl_zero_wr |=> !pin_latch_r [*2])
      else $error("zero control write did not force latch low");
endmodule // cpw_unit
`default_nettype wire

/* File: verif/cpw_pin_src.sv */
`default_nettype none
module cpw_pin_src (
   // clock
   input wire logic clock_in,
   // level on the shared pin
   output var logic pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // pin rests low; the port drive is part of this level
   initial pin_out = 1'b0;
   // each change is held several cycles so it is seen once only
   task automatic set_level(input logic v);
      @(posedge clock_in);
      pin_out <= v;
      repeat (4) @(posedge clock_in);
   endtask
   // one rising then one falling edge
   task automatic pulse();
      set_level(1'b1);
      set_level(1'b0);
   endtask
endmodule // cpw_pin_src
`default_nettype wire

/* File: verif/tb_capture_compare_pwm_unit.sv */
`default_nettype none
module tb_capture_compare_pwm_unit import cpw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] awa = '0;
   logic [ADDR_W-1:0] ara = '0;
   logic [31:0] wd = '0;
   logic [31:0] rdo;
   logic [31:0] rdat;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic awr, wrdy, bv, arr, rv, t1rst, t2clr, pin, src;
   logic [1:0] br, rr, resp;
   logic [15:0] t1 = 16'h0000;
   logic t1run = 1'b0;
   logic [9:0] q = 10'h000;
   logic [7:0] per = 8'h07;
   logic [3:0] cm [4] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLR, MODE_CMP_SOFT};
   logic [3:0] cp = 4'h3;
   int fail_count = 0, checks_done = 0, cyc = 0, trig = 0, clrs = 0, hi = 0, n = 0;

   always #4 clk = ~clk;

   cpw_unit i_dut (.clock_in(clk), .sys_rst_in(rst),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdo), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
      .timer_one_count_in(t1), .timer_one_reset_out(t1rst),
      .timer_two_count_in(q[9:2]), .timer_two_period_in(per), .timer_two_incr_in(q[1:0] == 2'h3),
      .timer_two_phase_in(q[1:0]), .timer_two_clear_out(t2clr),
      .shared_unit_pin_in(src), .unit_pin_out(pin));

   cpw_pin_src i_src (.clock_in(clk), .pin_out(src));

   // timer models: timer two wraps itself, timer one obeys the special event
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (t1rst) trig <= trig + 1;
      if (t2clr) clrs <= clrs + 1;
      if (t1run) t1 <= t1rst ? 16'h0000 : t1 + 16'h0001;
      q <= (q[1:0] == 2'h3 && q[9:2] == per) ? 10'h000 : q + 10'h001;
      // blocking count so the verdict below already sees the timeout
      if (cyc == 30000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // address and data offered together, each dropped when taken
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      awa <= a;
      wd <= {24'h000000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      resp = br;
      bry <= 1'b0;
   endtask

   task automatic rc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rdat = rdo;
      resp = rr;
      rry <= 1'b0;
      chk(nm, e, rdat);
   endtask

   // high cycles over exactly one pwm period of 32 clocks
   task automatic measure();
      repeat (40) @(posedge clk);
      hi = 0;
      repeat (32) begin
         @(posedge clk);
         if (pin) hi++;
      end
   endtask

   task automatic print_verdict();
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rc("ctrl_rst", ADDR_CTRL, 32'h0);
      rc("flags_rst", ADDR_FLAGS, 32'h0);
      wr(ADDR_ENABLES, 8'h04);
      rc("enables", ADDR_ENABLES, 32'h4);
      wr(ADDR_ENABLES, 8'h00);
      wr(ADDR_CTRL, 8'hF0);
      rc("ctrl_rw", ADDR_CTRL, 32'h30);
      wr(12'h004, 8'h55);
      chk("bad_wr", RESP_SLVERR, resp);
      rc("bad_rd", 12'h004, 32'h0);
      chk("bad_rd_resp", RESP_SLVERR, resp);
      // capture on rising edges; second capture overwrites unread first
      wr(ADDR_CTRL, {4'h0, MODE_CAP_RISE});
      t1 <= 16'hA1B2;
      i_src.pulse();
      t1 <= 16'hC3D4;
      i_src.pulse();
      rc("cap_lo", ADDR_VAL_LO, 32'hD4);
      rc("cap_hi", ADDR_VAL_HI, 32'hC3);
      rc("flag_set", ADDR_FLAGS, 32'h4);
      wr(ADDR_FLAGS, 8'h00);
      rc("flag_clr", ADDR_FLAGS, 32'h0);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CTRL, {4'h0, MODE_CAP_FALL});
      t1 <= 16'h1357;
      i_src.set_level(1'b1);
      rc("fall_hold", ADDR_VAL_LO, 32'hD4);
      i_src.set_level(1'b0);
      rc("fall_hi", ADDR_VAL_HI, 32'h13);
      // a partial count must be lost by passing through off
      wr(ADDR_CTRL, {4'h0, MODE_CAP_RISE4});
      repeat (2) i_src.pulse();
      for (int k = 0; k < 2; k++) begin
         n = (k == 1) ? 16 : 4;
         wr(ADDR_CTRL, 8'h00);
         wr(ADDR_CTRL, {4'h0, (k == 1) ? MODE_CAP_RISE16 : MODE_CAP_RISE4});
         t1 <= 16'h2460 + 16'(k);
         repeat (n - 1) i_src.pulse();
         rc("pre_hold", ADDR_VAL_LO, (k == 1) ? 32'h60 : 32'h57);
         i_src.pulse();
         rc("pre_fire", ADDR_VAL_LO, 32'h60 + 32'(k));
      end
      // compare actions: set, leave, clear, leave
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_VAL_LO, 8'h34);
      wr(ADDR_VAL_HI, 8'h12);
      for (int k = 0; k < 4; k++) begin
         t1 <= 16'h0000;
         wr(ADDR_FLAGS, 8'h00);
         wr(ADDR_CTRL, {4'h0, cm[k]});
         chk("cmp_idle", (k == 0) ? 1'b0 : cp[k - 1], pin);
         t1 <= 16'h1234;
         repeat (3) @(posedge clk);
         chk("cmp_pin", cp[k], pin);
         rc("cmp_flag", ADDR_FLAGS, 32'h4);
      end
      chk("no_trig", 32'h0, trig);
      t1 <= 16'h0000;
      wr(ADDR_VAL_HI, 8'h00);
      wr(ADDR_VAL_LO, 8'h10);
      wr(ADDR_CTRL, {4'h0, MODE_CMP_TRIG});
      t1run <= 1'b1;
      repeat (100) @(posedge clk);
      chk("t1_wrap", 32'h1, t1 <= 16'h0011);
      chk("trig_seen", 32'h1, trig > 3);
      t1run <= 1'b0;
      // pwm: duty 10 of 32, then zero duty, then duty beyond the period
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_VAL_LO, 8'h02);
      wr(ADDR_CTRL, 8'h2C);
      measure();
      // registered clear lands one cycle after the match, so duty 10 stands 11 clocks
      chk("pwm_hi", 32'h0B, hi);
      rc("duty_buf", ADDR_VAL_HI, 32'h02);
      wr(ADDR_VAL_HI, 8'h55);
      rc("hi_ro", ADDR_VAL_HI, 32'h02);
      chk("t2_clear", 32'h1, clrs > 0);
      wr(ADDR_VAL_LO, 8'h00);
      wr(ADDR_CTRL, 8'h0C);
      measure();
      chk("duty_zero", 32'h0, hi);
      wr(ADDR_VAL_LO, 8'hFF);
      measure();
      chk("duty_long", 32'h20, hi);
      wr(ADDR_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      chk("latch_low", 1'b0, pin);
      print_verdict();
   end
endmodule // tb_capture_compare_pwm_unit
`default_nettype wire
